// File: bench/sfpe_flash_model.sv
/*
 behavioural quad serial flash: latch, status, code read, page program
 into one page, erases recorded by opcode and address.
 assumes sclk idles low and the bench resolves the lines.
*/
`timescale 1ns/1ps
`default_nettype none
module sfpe_flash_model #(
   parameter logic [7:0] MAKER = 8'h5a, // arbitrary value
   parameter logic [7:0] PART = 8'h3c, // arbitrary value
   parameter realtime BUSY_NS = 100000.0
) (
   input wire logic sel_n_in,
   input wire logic sclk_in,
   input wire logic [3:0] line_in,
   output logic so_out
);
   logic [7:0] op_r, sh_r, e_op_r, mem[256], pend[256];
   logic [15:0] tx_r = '0;
   logic [23:0] adr_r, e_adr_r;
   logic wel_r = 0, hit;
   logic [4:0] prot_lvl = '0;
   logic prot_cmp = 0;
   bit pv[256];
   int nb;
   realtime t_end = 0;
   initial begin
      so_out = 0;
      foreach (mem[i]) mem[i] = 8'hff;
   end
   always @(negedge sel_n_in) begin
      nb = 0;
      foreach (pv[i]) pv[i] = 0;
   end
   always @(posedge sclk_in) if (!sel_n_in) begin
      if (op_r == 8'h32 && nb >= 32) begin
         sh_r = {sh_r[3:0], line_in};
         if (nb % 2 == 1) begin
            pend[adr_r[7:0]] = sh_r;
            pv[adr_r[7:0]] = 1;
            adr_r[7:0] = adr_r[7:0] + 8'h1;
         end
      end else begin
         sh_r = {sh_r[6:0], line_in[0]};
         if (nb == 7) op_r = sh_r;
         if (nb >= 8 && nb < 32) adr_r = {adr_r[22:0], line_in[0]};
      end
      nb++;
   end
   always @(negedge sclk_in) if (!sel_n_in) begin
      if (nb == 8 && op_r == 8'h05) tx_r = {6'h0, wel_r, $realtime < t_end, 8'h0};
      if (nb == 32 && op_r == 8'h90 && adr_r == 0) tx_r = {MAKER, PART};
      so_out = tx_r[15];
      tx_r = tx_r << 1;
   end
   always @(posedge sel_n_in) begin
      so_out = ~so_out;
      hit = 0;
      if ($realtime < t_end) hit = 0;
      else if (nb == 8 && op_r == 8'h06) wel_r = 1;
      else if (wel_r && ((op_r == 8'h60 || op_r == 8'hc7) ?
            prot_lvl[2:0] == {3{prot_cmp}} : prot_lvl == 0)) begin
         if (op_r == 8'h32 && nb > 32 && nb % 2 == 0) begin
            foreach (pv[i]) if (pv[i]) mem[i] = pend[i];
            hit = 1;
         end else if (nb == 32 && op_r inside {8'h20, 8'h52, 8'hd8} ||
               nb == 8 && op_r inside {8'h60, 8'hc7}) begin
            e_op_r = op_r;
            e_adr_r = adr_r;
            hit = 1;
         end
      end
      if (hit) begin
         wel_r = 0;
         t_end = $realtime + BUSY_NS;
      end
   end
endmodule
`default_nettype wire

// File: bench/sfpe_host_assertions.sv
/*
 pin and handshake checks for the flash host controller.
 assumes it is bound to sfpe_host; one clock, async active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module sfpe_host_checker (
   input wire logic CLK_SYS_IN,
   input wire logic RST_IN,
   input wire logic CMD_VALID_IN,
   input wire logic CMD_READY_OUT,
   input wire logic DONE_OUT,
   input wire logic FLASH_SEL_N_OUT,
   input wire logic FLASH_SCLK_OUT,
   input wire logic [3:0] QUAD_LINE_OUT
);
   default clocking @(posedge CLK_SYS_IN); endclocking
   default disable iff (RST_IN);
   a_take_select: assert property (CMD_VALID_IN && CMD_READY_OUT |=>
      !CMD_READY_OUT ##1 !FLASH_SEL_N_OUT)
      else $error("no select after take");
   a_sclk_high: assert property ($rose(FLASH_SCLK_OUT) |->
      FLASH_SCLK_OUT[*4] ##1 !FLASH_SCLK_OUT) else $error("sclk high width");
   a_sclk_low: assert property ($fell(FLASH_SCLK_OUT) |->
      !FLASH_SCLK_OUT[*4]) else $error("sclk low width");
   a_lines_hold: assert property (FLASH_SCLK_OUT |->
      $stable(QUAD_LINE_OUT)) else $error("lines moved while sclk high");
   a_sclk_frame: assert property (FLASH_SCLK_OUT |->
      !FLASH_SEL_N_OUT && !$past(FLASH_SEL_N_OUT))
      else $error("sclk outside frame");
   a_done_pulse: assert property (DONE_OUT |=> !DONE_OUT)
      else $error("done longer than one cycle");
   a_done_desel: assert property (DONE_OUT |->
      FLASH_SEL_N_OUT && $past(FLASH_SEL_N_OUT))
      else $error("done while selected");
   a_ready_idle: assert property (CMD_READY_OUT |-> FLASH_SEL_N_OUT)
      else $error("ready while selected");
   c_done: cover property (DONE_OUT);
   c_sel_rise: cover property ($rose(FLASH_SEL_N_OUT));
   c_take: cover property (CMD_VALID_IN && CMD_READY_OUT);
endmodule
bind sfpe_host sfpe_host_checker u_chk (.CLK_SYS_IN, .RST_IN,
   .CMD_VALID_IN, .CMD_READY_OUT, .DONE_OUT, .FLASH_SEL_N_OUT,
   .FLASH_SCLK_OUT, .QUAD_LINE_OUT);
`default_nettype wire

// File: bench/sfpe_testbench.sv
/*
 self-checking bench for the quad flash host: code read, status, random
 page programs with wrap, every erase kind, busy refusal, fifo full.
 assumes the behavioural flash model on the pins.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import sfpe_pkg::*;
   logic clk = 0, rst = 1, cv = 0, wv = 0;
   sfpe_cmd_t cmd = '0;
   logic [8:0] len = '0;
   logic [7:0] wd = '0;
   logic [3:0] qo, oe;
   wire logic [3:0] lw;
   logic rdy, wrdy, done, sel_n, sclk, so;
   sfpe_result_t res;
   int err_total = 0, n_tests = 0;
   logic [31:0] lf = 32'h5af1;
   logic [7:0] d[$];
   logic [7:0] exp_pg[256];
   always #50 clk = ~clk;
   assign lw = (~oe & qo) | (oe & {~qo[3:2], so, ~qo[0]});
   sfpe_host uut (.CLK_SYS_IN(clk), .RST_IN(rst), .CMD_VALID_IN(cv),
      .CMD_READY_OUT(rdy), .CMD_IN(cmd), .CMD_LEN_IN(len), .WR_DATA_IN(wd),
      .WR_VALID_IN(wv), .WR_READY_OUT(wrdy), .DONE_OUT(done),
      .RESULT_OUT(res), .FLASH_SEL_N_OUT(sel_n), .FLASH_SCLK_OUT(sclk),
      .QUAD_LINE_OUT(qo), .QUAD_LINE_OE_N_OUT(oe), .QUAD_LINE_IN(lw));
   sfpe_flash_model dev (.sel_n_in(sel_n), .sclk_in(sclk), .line_in(lw),
      .so_out(so));
   function automatic logic [31:0] rnd();
      lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
      return lf;
   endfunction
   task automatic chk(string what, logic [31:0] seen, logic [31:0] want);
      n_tests++;
      if (seen !== want) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, want, seen);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic run(sfpe_kind_t k, logic [23:0] a, int n);
      int i;
      @(negedge clk);
      while (rdy !== 1) @(negedge clk);
      cmd = '{k, a};
      len = 9'(n);
      cv = 1;
      @(negedge clk) cv = 0;
      for (i = 0; i < 60000 && done !== 1; i++) @(negedge clk);
      chk("done", done, 1);
   endtask
   task automatic wait_free();
      int i;
      run(SFPE_K_STATUS, 0, 0);
      for (i = 0; i < 100 && res.status[0] !== 0; i++) run(SFPE_K_STATUS, 0, 0);
   endtask
   task automatic push(logic [7:0] b);
      @(negedge clk);
      wd = b;
      wv = 1;
      // ready seen settled at a falling edge holds to the next rising one
      while (wrdy !== 1) @(negedge clk);
      @(negedge clk) wv = 0;
   endtask
   task automatic prog(logic [23:0] a, int n);
      int i;
      d.delete();
      for (i = 0; i < n; i++) begin
         d.push_back(8'(rnd()));
         exp_pg[8'(a[7:0] + i)] = d[i];
      end
      for (i = 0; i < n && i < 8; i++) push(d[i]);
      @(negedge clk);
      chk("fifo full", wrdy, 32'(n < 8));
      fork
         run(SFPE_K_PAGE, a, n);
         for (i = 8; i < n; i++) begin
            repeat (rnd() % 16) @(negedge clk);
            push(d[i]);
         end
      join
      run(SFPE_K_STATUS, 0, 0);
      chk("busy after program", res.status, 8'h01);
      wait_free();
      for (i = 0; i < 256; i++) chk("page byte", dev.mem[i], exp_pg[i]);
      $display("program test done");
   endtask
   initial begin
      #8000000;
      err_total++;
      end_of_test();
   end
   initial begin
      sfpe_kind_t kt[4];
      logic [7:0] ot[4];
      logic [23:0] a;
      int k;
      kt = '{SFPE_K_SECTOR, SFPE_K_BLK32, SFPE_K_BLK64, SFPE_K_CHIP};
      ot = '{8'h20, 8'h52, 8'hd8, 8'hc7};
      foreach (exp_pg[i]) exp_pg[i] = 8'hff;
      repeat (20) @(posedge clk);
      @(negedge clk) rst = 0;
      run(SFPE_K_STATUS, 0, 0);
      chk("idle status", res.status, 8'h00);
      run(SFPE_K_ID, 0, 0);
      chk("maker", res.maker, dev.MAKER);
      chk("part", res.part, dev.PART);
      $display("code read test done");
      prog(24'h0012f8, 12);
      prog(24'h001200, 260);
      for (k = 0; k < 4; k++) prog(24'(rnd()), 1 + rnd() % 40);
      for (k = 0; k < 4; k++) begin
         a = 24'(rnd());
         run(kt[k], a, 0);
         chk("erase op", dev.e_op_r, ot[k]);
         if (k < 3) chk("erase addr", dev.e_adr_r, a);
         run(SFPE_K_STATUS, 0, 0);
         chk("busy after erase", res.status, 8'h01);
         wait_free();
      end
      $display("erase test done");
      a = 24'(rnd());
      run(SFPE_K_SECTOR, a, 0);
      run(SFPE_K_SECTOR, ~a, 0);
      chk("erase while busy", dev.e_adr_r, a);
      wait_free();
      $display("busy test done");
      end_of_test();
   end
endmodule
`default_nettype wire

// File: rtl/sfpe_fifo.sv
/*
 small synchronous fifo of flip-flops, valid/ready on both sides.
 assumes one clock and an asynchronous active-high reset.
*/
`default_nettype none
`timescale 1ns/1ps
module sfpe_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 8
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [WIDTH-1:0] wr_data_in,
   input wire logic wr_valid_in,
   output logic wr_ready_out,
   output logic [WIDTH-1:0] rd_data_out,
   output logic rd_valid_out,
   input wire logic rd_ready_in
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0] cnt_r;
   logic do_wr;
   logic do_rd;

   assign wr_ready_out = cnt_r != (AW+1)'(DEPTH);
   assign rd_valid_out = cnt_r != '0;
   assign rd_data_out = mem_r[rp_r];
   assign do_wr = wr_valid_in && wr_ready_out;
   assign do_rd = rd_valid_out && rd_ready_in;

   always_ff @(posedge clk_in) begin
      if (do_wr) begin
         mem_r[wp_r] <= wr_data_in;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         if (do_wr) begin
            wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
         end
         if (do_rd) begin
            rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
         end
         cnt_r <= cnt_r + (AW+1)'(do_wr) - (AW+1)'(do_rd);
      end
   end
endmodule
`default_nettype wire

// File: rtl/sfpe_host.sv
/*
 host controller for a quad serial nor flash: write-latch set, quad page
 program, sector/block/chip erase, maker/part code read, status read.
 assumes the flash on the pins, serial clock made here by a divider,
 page data pushed into the byte fifo before or during the command.
*/
// Contract
// - write latch set, then select low, 32H, three address bytes, data.
// - program data bytes go over all four quad lines together.
// - select rises only after a whole data byte, else nothing programmed.
// - sector erase is 20H plus three address bytes, latch set.
// - sector erase select rises right after the third address byte.
// - 32KB block erase is 52H plus address, latch set.
// - 64KB block erase is D8H plus address, latch set.
// - block erase select rises right after the last address bit.
// - select stays low from opcode through last address bit.
// - chip erase is 60H or C7H, select rises after opcode.
// - code read: 90H, 24-bit zero address, then maker and part.
`default_nettype none
`timescale 1ns/1ps
module sfpe_host
   import sfpe_pkg::*;
(
   input wire logic CLK_SYS_IN,
   input wire logic RST_IN,
   input wire logic CMD_VALID_IN,
   output logic CMD_READY_OUT,
   input wire sfpe_cmd_t CMD_IN,
   input wire logic [8:0] CMD_LEN_IN,
   input wire logic [7:0] WR_DATA_IN,
   input wire logic WR_VALID_IN,
   output logic WR_READY_OUT,
   output logic DONE_OUT,
   output sfpe_result_t RESULT_OUT,
   output logic FLASH_SEL_N_OUT,
   output logic FLASH_SCLK_OUT,
   output logic [3:0] QUAD_LINE_OUT,
   output logic [3:0] QUAD_LINE_OE_N_OUT,
   input wire logic [3:0] QUAD_LINE_IN
);
   sfpe_state_t state_r;
   sfpe_cmd_t cmd_r;
   logic [1:0] div_r;
   logic sclk_r;
   logic rise_en;
   logic fall_en;
   logic [4:0] bit_r;
   logic [8:0] left_r;
   logic [31:0] shift_r;
   logic nib_hi_r;
   logic [23:0] rx_r;
   logic [3:0] in_meta_r;
   logic [3:0] in_sync_r;
   logic [7:0] fifo_data;
   logic fifo_valid;
   logic fifo_take;
   sfpe_result_t result_r;
   logic done_r;

   function automatic logic [7:0] opcode_of(input sfpe_kind_t k,
                                            input logic [7:0] dflt);
      case (k)
         SFPE_K_PAGE: opcode_of = OP_QUAD_PAGE;
         SFPE_K_SECTOR: opcode_of = OP_SECTOR;
         SFPE_K_BLK32: opcode_of = OP_BLK32;
         SFPE_K_BLK64: opcode_of = OP_BLK64;
         SFPE_K_CHIP: opcode_of = OP_CHIP_B;
         SFPE_K_ID: opcode_of = OP_IDREAD;
         default: opcode_of = dflt;
      endcase
   endfunction

   function automatic logic needs_wel(input sfpe_kind_t k);
      needs_wel = (k != SFPE_K_ID) && (k != SFPE_K_STATUS);
   endfunction

   sfpe_fifo #(
      .WIDTH(FIFO_WIDTH),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_in(CLK_SYS_IN),
      .rst_in(RST_IN),
      .wr_data_in(WR_DATA_IN),
      .wr_valid_in(WR_VALID_IN),
      .wr_ready_out(WR_READY_OUT),
      .rd_data_out(fifo_data),
      .rd_valid_out(fifo_valid),
      .rd_ready_in(fifo_take)
   );

   // serial clock divider; edges only while a frame runs
   assign rise_en = (div_r == HALF_CYC_W) && !sclk_r;
   assign fall_en = (div_r == HALF_CYC_W) && sclk_r;

   logic running;
   assign running = (state_r == SFPE_WEL) || (state_r == SFPE_OPC) ||
                    (state_r == SFPE_ADDR) || (state_r == SFPE_DATA) ||
                    (state_r == SFPE_READ);
   // data stalls the clock low until the fifo has the next byte
   logic stall;
   assign stall = (state_r == SFPE_DATA) && !sclk_r && nib_hi_r &&
                  !fifo_valid;

   always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
      if (RST_IN) begin
         div_r <= RST_HALF;
         sclk_r <= 1'b0;
      end else if (!running || stall) begin
         div_r <= RST_HALF;
         sclk_r <= 1'b0;
      end else if (div_r == HALF_CYC_W) begin
         div_r <= RST_HALF;
         sclk_r <= !sclk_r;
      end else begin
         div_r <= div_r + 2'h1;
      end
   end

   always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
      if (RST_IN) begin
         in_meta_r <= 4'h0;
         in_sync_r <= 4'h0;
      end else begin
         in_meta_r <= QUAD_LINE_IN;
         in_sync_r <= in_meta_r;
      end
   end

   assign CMD_READY_OUT = state_r == SFPE_IDLE;
   // head byte leaves the fifo at the fall that ends its lower nibble
   assign fifo_take = (state_r == SFPE_DATA) && fall_en && !nib_hi_r &&
                      (bit_r == 5'h0) && (left_r != 9'h0);

   always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
      if (RST_IN) begin
         state_r <= SFPE_IDLE;
         cmd_r <= '0;
         bit_r <= 5'h0;
         left_r <= 9'h0;
         shift_r <= 32'h0;
         nib_hi_r <= 1'b1;
         rx_r <= 24'h0;
         result_r <= '0;
         done_r <= 1'b0;
      end else begin
         done_r <= 1'b0;
         case (state_r)
            SFPE_IDLE: begin
               if (CMD_VALID_IN) begin
                  cmd_r <= CMD_IN;
                  left_r <= CMD_LEN_IN;
                  bit_r <= 5'h7;
                  if (needs_wel(CMD_IN.kind)) begin
                     shift_r <= {OP_SET_WEL, 24'h0};
                     state_r <= SFPE_WEL;
                  end else begin
                     shift_r <= {opcode_of(CMD_IN.kind, OP_STATUS),
                                 (CMD_IN.kind == SFPE_K_ID) ? ID_ADDR
                                 : CMD_IN.addr};
                     state_r <= SFPE_OPC;
                  end
               end
            end
            SFPE_WEL: begin
               if (fall_en) begin
                  if (bit_r == 5'h0) begin
                     state_r <= SFPE_GAP;
                  end else begin
                     bit_r <= bit_r - 5'h1;
                     shift_r <= {shift_r[30:0], 1'b0};
                  end
               end
            end
            SFPE_GAP: begin
               bit_r <= 5'h7;
               shift_r <= {opcode_of(cmd_r.kind, OP_STATUS), cmd_r.addr};
               state_r <= SFPE_OPC;
            end
            SFPE_OPC: begin
               if (fall_en) begin
                  shift_r <= {shift_r[30:0], 1'b0};
                  if (bit_r != 5'h0) begin
                     bit_r <= bit_r - 5'h1;
                  end else if (cmd_r.kind == SFPE_K_CHIP) begin
                     state_r <= SFPE_FIN;
                  end else if (cmd_r.kind == SFPE_K_STATUS) begin
                     bit_r <= 5'h7;
                     state_r <= SFPE_READ;
                  end else begin
                     bit_r <= 5'h17;
                     state_r <= SFPE_ADDR;
                  end
               end
            end
            SFPE_ADDR: begin
               if (fall_en) begin
                  shift_r <= {shift_r[30:0], 1'b0};
                  if (bit_r != 5'h0) begin
                     bit_r <= bit_r - 5'h1;
                  end else if (cmd_r.kind == SFPE_K_PAGE) begin
                     bit_r <= 5'h0;
                     nib_hi_r <= 1'b1;
                     state_r <= SFPE_DATA;
                  end else if (cmd_r.kind == SFPE_K_ID) begin
                     bit_r <= 5'hf;
                     state_r <= SFPE_READ;
                  end else begin
                     state_r <= SFPE_FIN;
                  end
               end
            end
            SFPE_DATA: begin
               // byte loads as two nibbles, upper first
               if (fall_en) begin
                  nib_hi_r <= !nib_hi_r;
                  if (!nib_hi_r) begin
                     left_r <= left_r - 9'h1;
                     // end on the byte boundary of the last byte
                     if (left_r <= 9'h1) begin
                        state_r <= SFPE_FIN;
                     end
                  end
               end
               if (sclk_r == 1'b0 && nib_hi_r && fifo_valid &&
                   div_r == RST_HALF) begin
                  shift_r <= {fifo_data, 24'h0};
               end else if (fall_en && nib_hi_r) begin
                  shift_r <= {shift_r[27:0], 4'h0};
               end
            end
            SFPE_READ: begin
               if (rise_en) begin
                  rx_r <= {rx_r[22:0], in_sync_r[1]};
               end
               if (fall_en) begin
                  if (bit_r == 5'h0) begin
                     state_r <= SFPE_FIN;
                  end else begin
                     bit_r <= bit_r - 5'h1;
                  end
               end
            end
            SFPE_FIN: begin
               state_r <= SFPE_DONE;
            end
            SFPE_DONE: begin
               if (cmd_r.kind == SFPE_K_ID) begin
                  result_r.maker <= rx_r[15:8];
                  result_r.part <= rx_r[7:0];
               end else if (cmd_r.kind == SFPE_K_STATUS) begin
                  result_r.status <= rx_r[7:0];
               end
               done_r <= 1'b1;
               state_r <= SFPE_IDLE;
            end
            default: state_r <= SFPE_IDLE;
         endcase
      end
   end

   // drive on falling edges so the device samples on rising
   always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
      if (RST_IN) begin
         FLASH_SEL_N_OUT <= 1'b1;
         QUAD_LINE_OUT <= 4'h0;
         QUAD_LINE_OE_N_OUT <= 4'hf;
      end else begin
         FLASH_SEL_N_OUT <= !running;
         if (state_r == SFPE_DATA) begin
            // the lower nibble is shifted up into the top at the first fall
            QUAD_LINE_OUT <= shift_r[31:28];
            QUAD_LINE_OE_N_OUT <= 4'h0;
         end else if (running && state_r != SFPE_READ) begin
            QUAD_LINE_OUT <= {3'h0, shift_r[31]};
            QUAD_LINE_OE_N_OUT <= 4'he;
         end else begin
            QUAD_LINE_OUT <= 4'h0;
            QUAD_LINE_OE_N_OUT <= 4'hf;
         end
      end
   end

   assign FLASH_SCLK_OUT = sclk_r;
   assign DONE_OUT = done_r;
   assign RESULT_OUT = result_r;
endmodule
`default_nettype wire

// File: shared/sfpe_pkg.sv
/*
 package for the serial flash host controller: opcodes, command kinds,
 link timing and the packed structs carried between the user port and
 the engine. no timescale; imported whole by sfpe_host and the testbench.
*/
`default_nettype none
package sfpe_pkg;
   localparam logic [7:0] OP_QUAD_PAGE = 8'h32;
   localparam logic [7:0] OP_SECTOR = 8'h20;
   localparam logic [7:0] OP_BLK32 = 8'h52;
   localparam logic [7:0] OP_BLK64 = 8'hd8;
   localparam logic [7:0] OP_CHIP_A = 8'h60;
   localparam logic [7:0] OP_CHIP_B = 8'hc7;
   localparam logic [7:0] OP_IDREAD = 8'h90;
   localparam logic [7:0] OP_SET_WEL = 8'h06;
   localparam logic [7:0] OP_STATUS = 8'h05;
   localparam logic [23:0] ID_ADDR = 24'h000000;
   localparam int unsigned PAGE_BYTES = 256;
   localparam int unsigned FIFO_DEPTH = 8;
   localparam int unsigned FIFO_WIDTH = 8;
   // serial clock period in system clocks (10 MHz / 8)
   localparam int unsigned CLK_NS = 100;
   localparam int unsigned SCLK_NS = 800;
   localparam int unsigned HALF_CYC = SCLK_NS / CLK_NS / 2;
   localparam logic [1:0] HALF_CYC_W = 2'(HALF_CYC - 1);
   localparam logic [1:0] RST_HALF = 2'h0;
   localparam int unsigned WIP_BIT = 0;
   localparam int unsigned WEL_BIT = 1;

   typedef enum logic [2:0] {
      SFPE_K_PAGE = 3'h0,
      SFPE_K_SECTOR = 3'h1,
      SFPE_K_BLK32 = 3'h2,
      SFPE_K_BLK64 = 3'h3,
      SFPE_K_CHIP = 3'h4,
      SFPE_K_ID = 3'h5,
      SFPE_K_STATUS = 3'h6
   } sfpe_kind_t;

   typedef struct packed {
      sfpe_kind_t kind;
      logic [23:0] addr;
   } sfpe_cmd_t;

   typedef struct packed {
      logic [7:0] maker;
      logic [7:0] part;
      logic [7:0] status;
   } sfpe_result_t;

   typedef enum logic [3:0] {
      SFPE_IDLE = 4'b0000,
      SFPE_WEL = 4'b0001,
      SFPE_GAP = 4'b0011,
      SFPE_OPC = 4'b0010,
      SFPE_ADDR = 4'b0110,
      SFPE_DATA = 4'b0111,
      SFPE_READ = 4'b0101,
      SFPE_FIN = 4'b0100,
      SFPE_DONE = 4'b1100
   } sfpe_state_t;
endpackage
`default_nettype wire
